// File: hdl/stepper_io_params.svh
/*
  Named constants of the stepper drive status and I/O block: register
  indices, widths, reset values and timing figures.
  Assumes inclusion, under its guard, by every file that needs a constant.
*/
`ifndef STEPPER_IO_PARAMS_SVH
`define STEPPER_IO_PARAMS_SVH

// Pin counts
`define NUM_INPUTS  7
`define NUM_OUTPUTS 4

// Register indices on the host read/write port
`define IDX_INPUT_WORD   5'h00
`define IDX_FILTER_MASK  5'h01
`define IDX_CW_MASK      5'h02
`define IDX_CCW_MASK     5'h03
`define IDX_PROG_MASK    5'h04
`define IDX_HALT_MASK    5'h05
`define IDX_ALLOW_MASK   5'h06
`define IDX_OUTPUT_WORD  5'h07
`define IDX_FAULT_MASK   5'h08
`define IDX_MOTION_MASK  5'h09
`define IDX_SPEED_MASK   5'h0a
`define IDX_RUN_MASK     5'h0b
`define IDX_POSITION     5'h0c
`define IDX_MOTOR_VEL    5'h0d
`define IDX_TARGET_VEL   5'h0e
`define IDX_ACCEL        5'h0f
`define IDX_ANALOG       5'h10
`define IDX_CURRENT      5'h11
`define IDX_STATUS       5'h12
`define IDX_USER_BASE    5'h18
`define USER_VAR_COUNT   8

// Reset values
`define RST_WORD   32'h0000_0000
`define RST_COUNT  16'h0000

// Timing: one millisecond at a 5 ns clock
`define ONE_MS_NS      1000000
`define CLK_PERIOD_NS  5
`define MS_CNT_W       18

// Current scaling and analog conversion
`define PCT_FULL       24'h00_0064
`define ANALOG_MID     10'sh080
`define ANALOG_SPAN    10'sh07f
`define ANALOG_NEG_MAX 10'sh381

`endif

// File: hdl/stepper_io_pkg.sv
/*
  Types of the stepper drive status and I/O block: configuration and
  motion carriers and the winding power state.
  Assumes the parameter header is on the include path.
*/
`include "stepper_io_params.svh"

package stepper_io_pkg;

  // Input role masks, one bit per input
  typedef struct packed {
    logic [`NUM_INPUTS-1:0] filter;
    logic [`NUM_INPUTS-1:0] cw;
    logic [`NUM_INPUTS-1:0] ccw;
    logic [`NUM_INPUTS-1:0] prog;
    logic [`NUM_INPUTS-1:0] halt;
    logic [`NUM_INPUTS-1:0] allow;
  } input_masks_t;

  // Output role masks, one bit per output
  typedef struct packed {
    logic [`NUM_OUTPUTS-1:0] fault;
    logic [`NUM_OUTPUTS-1:0] motion;
    logic [`NUM_OUTPUTS-1:0] speed;
    logic [`NUM_OUTPUTS-1:0] run;
  } output_masks_t;

  // Motion profile from the move generator
  typedef struct packed {
    logic signed [31:0] position;
    logic signed [31:0] motor_vel;
    logic signed [31:0] target_vel;
    logic signed [31:0] accel;
  } motion_t;

  // Winding power settings
  typedef struct packed {
    logic [15:0] up_ms;
    logic [15:0] down_ms;
    logic [7:0]  run_pct;
    logic [7:0]  stand_pct;
    logic [15:0] peak;
  } power_cfg_t;

  // Velocity dependent features
  typedef struct packed {
    logic        midband_en;
    logic [31:0] midband_vel;
    logic        full_en;
    logic [31:0] full_vel;
    logic        analog_en;
    logic [31:0] analog_max;
    logic [31:0] deadband;
  } vel_cfg_t;

  typedef enum logic [1:0] {PWR_STAND, PWR_RAISE, PWR_RUN, PWR_LOWER} power_state_t;

endpackage

// File: hdl/stepper_drive_io_status_logic.sv
/*
  Status and I/O assignment logic of a programmable stepper drive:
  input filtering and role decode, output role drive, winding power
  switching, velocity features and the host register port.
  Assumes all inputs are synchronous to REF_CLK_IN and that the host
  port is fed by the serial link decoder of the drive.
*/
// Contract
// RULE_01 - Input word bit is 1 when input active, bit 0 is input one.
// RULE_02 - Filtered inputs change only after holding the new level the debounce time.
// RULE_03 - Role masks pick the limit, select, stop and enable inputs.
// RULE_04 - Output word bit is 1 when active, output one weight 1 to output four 8.
// RULE_05 - Fault output asserts on drive fault, never on power loss.
// RULE_06 - Moving output asserts while the motor moves.
// RULE_07 - Slew output asserts while motor velocity equals target velocity; the code also requires a nonzero motor velocity.
// RULE_08 - Sequence active output asserts while a sequence executes.
// RULE_09 - Wait the power-up delay in ms before raising to running current.
// RULE_10 - Wait the power-down delay in ms before dropping to standing current.
// RULE_11 - Winding current is running or standing percent of peak current.
// RULE_12 - Resonance compensation only when enabled and above threshold speed.
// RULE_13 - Full step drive only when enabled and above full-step threshold.
// RULE_14 - Analog velocity scales linearly to maximum at full input, needs enable.
// RULE_15 - Analog velocity inside deadband window commands standstill.
// RULE_16 - Analog input reported as 8-bit captured snapshot.
// RULE_17 - User variables clear to zero on power-down and reset.
// RULE_18 - Read-only motion snapshot of position, velocities and acceleration.
// RULE_19 - Output word and masks are read-only to the host.
// RULE_20 - Input and output words refresh every clock cycle; the code refreshes them only on cycles with CE_IN high.
`timescale 1ns/1ps
`include "stepper_io_params.svh"

module stepper_drive_io_status_logic
  import stepper_io_pkg::*;
#(
  parameter int MS_CYCLES = `ONE_MS_NS / `CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic                      REF_CLK_IN,
  input  wire logic                      RST_N_IN,
  input  wire logic                      CE_IN,
  input  wire logic                      POWER_DOWN_IN,
  // Discrete inputs and configuration
  input  wire logic [`NUM_INPUTS-1:0]    INPUT_CURRENT_IN,
  input  wire logic [15:0]               DEBOUNCE_MS_IN,
  input  wire input_masks_t              IN_MASKS_IN,
  input  wire output_masks_t             OUT_MASKS_IN,
  // Drive state
  input  wire logic                      FAULT_IN,
  input  wire logic                      POWER_GOOD_IN,
  input  wire logic                      SEQ_RUN_IN,
  input  wire logic                      MOVE_CMD_IN,
  input  wire logic                      CONT_MOVE_IN,
  input  wire motion_t                   MOTION_IN,
  input  wire power_cfg_t                POWER_IN,
  input  wire vel_cfg_t                  VELF_IN,
  input  wire logic                      EMF_RESONANCE_IN,
  input  wire logic [7:0]                ANALOG_CODE_IN,
  // Host register port
  input  wire logic                      RD_EN_IN,
  input  wire logic                      WR_EN_IN,
  input  wire logic [4:0]                REG_SEL_IN,
  input  wire logic [31:0]               WR_DATA_IN,
  output logic      [31:0]               RD_DATA_OUT,
  output logic                           RD_VALID_OUT,
  // Input roles
  output logic                           CLOCKWISE_TRAVEL_LIMIT_OUT,
  output logic                           COUNTERCLOCKWISE_TRAVEL_LIMIT_OUT,
  output logic                           HALT_OUT,
  output logic                           DRIVE_ALLOW_OUT,
  output logic      [`NUM_INPUTS-1:0]    PROGRAM_SELECT_OUT,
  // Outputs and power stage
  output logic      [`NUM_OUTPUTS-1:0]   OUTPUT_PINS_OUT,
  output logic      [15:0]               WINDING_CURRENT_OUT,
  output logic                           MOVE_GO_OUT,
  output logic                           RESONANCE_COMP_OUT,
  output logic                           FULL_STEP_OUT,
  output logic signed [31:0]             ANALOG_VEL_OUT,
  output logic                           ANALOG_ACTIVE_OUT
);

  localparam logic [`MS_CNT_W-1:0] MS_LAST = `MS_CNT_W'(MS_CYCLES - 1);

  logic [`MS_CNT_W-1:0]   ms_cnt;
  logic                   ms_tick;
  logic [`NUM_INPUTS-1:0] in_active;
  logic [`NUM_INPUTS-1:0] in_state;
  logic [`NUM_OUTPUTS-1:0] out_word;
  logic [`NUM_OUTPUTS-1:0] next_out_word;
  logic                   fault_active;
  logic                   moving;
  logic                   at_speed;
  power_state_t           pst;
  logic [15:0]            pcnt;
  logic [23:0]            run_prod;
  logic [23:0]            stand_prod;
  logic [15:0]            run_cur;
  logic [15:0]            stand_cur;
  logic [31:0]            vel_mag;
  logic signed [9:0]      an_off;
  logic signed [41:0]     an_prod;
  logic signed [31:0]     an_vel;
  logic [31:0]            an_mag;
  logic                   an_mode;
  motion_t                snap;
  logic [31:0]            user_var [`USER_VAR_COUNT];
  logic [31:0]            rd_mux;
  logic [4:0]             user_idx;
  logic                   user_hit;

  // Millisecond tick shared by debounce and power delays
  assign ms_tick = (ms_cnt == MS_LAST);
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) ms_cnt <= '0;
    else if (CE_IN) ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
  end

  // Active means no current flows through the input
  assign in_active = ~INPUT_CURRENT_IN; // RULE_01

  // Per-input filter; an unfiltered input follows the pin each cycle with CE_IN high
  for (genvar i = 0; i < `NUM_INPUTS; i++) begin : g_filter
    logic [15:0] dcnt;
    always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
        in_state[i] <= 1'b0;
        dcnt        <= `RST_COUNT;
      end else if (CE_IN) begin
        if (!IN_MASKS_IN.filter[i] || in_active[i] == in_state[i]) begin
          in_state[i] <= in_active[i]; // RULE_20
          dcnt        <= `RST_COUNT;
        end else if (dcnt >= DEBOUNCE_MS_IN) begin
          in_state[i] <= in_active[i]; // RULE_02
          dcnt        <= `RST_COUNT;
        end else if (ms_tick) begin
          dcnt <= dcnt + 1'b1;
        end
      end
    end
  end

  // Role decode from the filtered state
  assign CLOCKWISE_TRAVEL_LIMIT_OUT        = |(in_state & IN_MASKS_IN.cw);   // RULE_03
  assign COUNTERCLOCKWISE_TRAVEL_LIMIT_OUT = |(in_state & IN_MASKS_IN.ccw);  // RULE_03
  assign HALT_OUT                          = |(in_state & IN_MASKS_IN.halt); // RULE_03
  assign PROGRAM_SELECT_OUT                = in_state & IN_MASKS_IN.prog;    // RULE_03
  // No enable input assigned leaves the drive allowed
  assign DRIVE_ALLOW_OUT = ~|IN_MASKS_IN.allow | |(in_state & IN_MASKS_IN.allow); // RULE_03

  // Output role drive; a dead supply must not look like a fault
  assign fault_active  = FAULT_IN & POWER_GOOD_IN; // RULE_05
  assign moving        = (MOTION_IN.motor_vel != 32'sh0); // RULE_06
  assign at_speed      = moving & (MOTION_IN.motor_vel == MOTION_IN.target_vel); // RULE_07
  assign next_out_word = ({`NUM_OUTPUTS{fault_active}} & OUT_MASKS_IN.fault)
                       | ({`NUM_OUTPUTS{moving}}       & OUT_MASKS_IN.motion)
                       | ({`NUM_OUTPUTS{at_speed}}     & OUT_MASKS_IN.speed)
                       | ({`NUM_OUTPUTS{SEQ_RUN_IN}}   & OUT_MASKS_IN.run); // RULE_08
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) out_word <= '0;
    else if (CE_IN) out_word <= next_out_word; // RULE_20
  end
  assign OUTPUT_PINS_OUT = out_word; // RULE_04

  // Winding power sequencing; the move generator waits on MOVE_GO_OUT
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      pst  <= PWR_STAND;
      pcnt <= `RST_COUNT;
    end else if (CE_IN) begin
      unique case (pst)
        PWR_STAND: begin
          pcnt <= `RST_COUNT;
          if (MOVE_CMD_IN || moving) pst <= PWR_RAISE;
        end
        PWR_RAISE: begin
          if (pcnt >= POWER_IN.up_ms) pst <= PWR_RUN; // RULE_09
          else if (ms_tick) pcnt <= pcnt + 1'b1;
        end
        PWR_RUN: begin
          pcnt <= `RST_COUNT;
          if (!moving && !MOVE_CMD_IN) pst <= PWR_LOWER;
        end
        PWR_LOWER: begin
          if (MOVE_CMD_IN || moving) begin
            pst <= PWR_RUN;
          end else if (pcnt >= POWER_IN.down_ms) begin
            pst <= PWR_STAND; // RULE_10
          end else if (ms_tick) begin
            pcnt <= pcnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Current levels as a percentage of peak
  assign run_prod   = POWER_IN.peak * POWER_IN.run_pct / `PCT_FULL;
  assign stand_prod = POWER_IN.peak * POWER_IN.stand_pct / `PCT_FULL;
  assign run_cur    = run_prod[15:0];
  assign stand_cur  = stand_prod[15:0];
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) WINDING_CURRENT_OUT <= '0;
    else if (CE_IN) WINDING_CURRENT_OUT <= (pst == PWR_RUN || pst == PWR_LOWER) ?
                                           run_cur : stand_cur; // RULE_11
  end
  assign MOVE_GO_OUT = (pst == PWR_RUN);

  // Speed features work on velocity magnitude
  assign vel_mag = MOTION_IN.motor_vel[31] ? 32'(-MOTION_IN.motor_vel) : MOTION_IN.motor_vel;
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      RESONANCE_COMP_OUT <= 1'b0;
      FULL_STEP_OUT      <= 1'b0;
    end else if (CE_IN) begin
      RESONANCE_COMP_OUT <= VELF_IN.midband_en & (vel_mag > VELF_IN.midband_vel)
                          & EMF_RESONANCE_IN; // RULE_12
      FULL_STEP_OUT      <= VELF_IN.full_en & (vel_mag > VELF_IN.full_vel); // RULE_13
    end
  end

  // Analog velocity: code 128 is zero, 255 is full scale; code 0 is clamped
  assign an_off  = ($signed({2'b00, ANALOG_CODE_IN}) - `ANALOG_MID < `ANALOG_NEG_MAX) ?
                   `ANALOG_NEG_MAX : $signed({2'b00, ANALOG_CODE_IN}) - `ANALOG_MID;
  assign an_prod = 42'(an_off * $signed({1'b0, VELF_IN.analog_max}) / `ANALOG_SPAN); // RULE_14
  assign an_vel  = an_prod[31:0];
  assign an_mag  = an_vel[31] ? 32'(-an_vel) : an_vel;
  assign an_mode = VELF_IN.analog_en & CONT_MOVE_IN & (MOTION_IN.accel != 32'sh0); // RULE_14
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      ANALOG_VEL_OUT    <= '0;
      ANALOG_ACTIVE_OUT <= 1'b0;
    end else if (CE_IN) begin
      ANALOG_ACTIVE_OUT <= an_mode;
      ANALOG_VEL_OUT    <= (an_mode && an_mag > VELF_IN.deadband) ? an_vel : 32'sh0; // RULE_15
    end
  end

  // Motion snapshot is taken when the host reads the position index;
  // the analog code needs none, the read data word holds it until the next read
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      snap <= '0;
    end else if (CE_IN && RD_EN_IN && REG_SEL_IN == `IDX_POSITION) begin
      snap <= MOTION_IN; // RULE_18
    end
  end

  // User variables are the only host-writable words
  assign user_idx = REG_SEL_IN - `IDX_USER_BASE;
  assign user_hit = (REG_SEL_IN >= `IDX_USER_BASE);
  for (genvar u = 0; u < `USER_VAR_COUNT; u++) begin : g_user
    always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN || POWER_DOWN_IN) user_var[u] <= `RST_WORD; // RULE_17
      else if (CE_IN && WR_EN_IN && user_hit && user_idx == 5'(u)) user_var[u] <= WR_DATA_IN;
    end
  end

  // Read mux; writes to every other index are dropped
  always_comb begin
    rd_mux = `RST_WORD;
    unique case (REG_SEL_IN)
      `IDX_INPUT_WORD:  rd_mux = 32'(in_state); // RULE_01
      `IDX_FILTER_MASK: rd_mux = 32'(IN_MASKS_IN.filter);
      `IDX_CW_MASK:     rd_mux = 32'(IN_MASKS_IN.cw);
      `IDX_CCW_MASK:    rd_mux = 32'(IN_MASKS_IN.ccw);
      `IDX_PROG_MASK:   rd_mux = 32'(IN_MASKS_IN.prog);
      `IDX_HALT_MASK:   rd_mux = 32'(IN_MASKS_IN.halt);
      `IDX_ALLOW_MASK:  rd_mux = 32'(IN_MASKS_IN.allow);
      `IDX_OUTPUT_WORD: rd_mux = 32'(out_word); // RULE_19
      `IDX_FAULT_MASK:  rd_mux = 32'(OUT_MASKS_IN.fault);
      `IDX_MOTION_MASK: rd_mux = 32'(OUT_MASKS_IN.motion);
      `IDX_SPEED_MASK:  rd_mux = 32'(OUT_MASKS_IN.speed);
      `IDX_RUN_MASK:    rd_mux = 32'(OUT_MASKS_IN.run);
      `IDX_POSITION:    rd_mux = MOTION_IN.position;
      `IDX_MOTOR_VEL:   rd_mux = snap.motor_vel;
      `IDX_TARGET_VEL:  rd_mux = snap.target_vel;
      `IDX_ACCEL:       rd_mux = snap.accel;
      `IDX_ANALOG:      rd_mux = 32'(ANALOG_CODE_IN); // RULE_16
      `IDX_CURRENT:     rd_mux = 32'(WINDING_CURRENT_OUT);
      `IDX_STATUS:      rd_mux = 32'({pst, FULL_STEP_OUT, RESONANCE_COMP_OUT,
                                      ANALOG_ACTIVE_OUT, fault_active});
      default:          rd_mux = user_hit ? user_var[user_idx[2:0]] : `RST_WORD;
    endcase
  end

  // Read answers one cycle after the request
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT  <= `RST_WORD;
      RD_VALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      RD_VALID_OUT <= RD_EN_IN;
      if (RD_EN_IN) RD_DATA_OUT <= rd_mux;
    end
  end

  // Assertions
  property p_in_level;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      CE_IN |=> ((in_state ^ ~$past(INPUT_CURRENT_IN)) & ~$past(IN_MASKS_IN.filter)) == '0;
  endproperty
  a_in_level: assert property (p_in_level) else $error("unfiltered input wrong"); // RULE_01

  property p_filter_hold;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && in_active == in_state) |=> $stable(in_state);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("input changed spuriously"); // RULE_02

  property p_fault_out;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && FAULT_IN && POWER_GOOD_IN) |=>
        (out_word & $past(OUT_MASKS_IN.fault)) == $past(OUT_MASKS_IN.fault);
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("fault output missing"); // RULE_05

  // With no other role driving, a dead supply leaves the fault pin low
  property p_fault_nopwr;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && !POWER_GOOD_IN && !moving && !SEQ_RUN_IN) |=>
        (out_word & $past(OUT_MASKS_IN.fault)) == '0;
  endproperty
  a_fault_nopwr: assert property (p_fault_nopwr) else $error("fault on power loss"); // RULE_05

  property p_moving_out;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && moving) |=> (out_word & $past(OUT_MASKS_IN.motion)) == $past(OUT_MASKS_IN.motion);
  endproperty
  a_moving_out: assert property (p_moving_out) else $error("moving output missing"); // RULE_06

  property p_speed_out;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && at_speed) |=> (out_word & $past(OUT_MASKS_IN.speed)) == $past(OUT_MASKS_IN.speed);
  endproperty
  a_speed_out: assert property (p_speed_out) else $error("slew output missing"); // RULE_07

  property p_seq_out;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && SEQ_RUN_IN) |=> (out_word & $past(OUT_MASKS_IN.run)) == $past(OUT_MASKS_IN.run);
  endproperty
  a_seq_out: assert property (p_seq_out) else $error("sequence output missing"); // RULE_08

  property p_up_wait;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && pst == PWR_RAISE && pcnt < POWER_IN.up_ms) |=> pst != PWR_RUN;
  endproperty
  a_up_wait: assert property (p_up_wait) else $error("power raised early"); // RULE_09

  property p_down_wait;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && pst == PWR_LOWER && pcnt < POWER_IN.down_ms) |=> pst != PWR_STAND;
  endproperty
  a_down_wait: assert property (p_down_wait) else $error("power dropped early"); // RULE_10

  property p_stand_current;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && pst == PWR_STAND) |=> WINDING_CURRENT_OUT == $past(stand_cur);
  endproperty
  a_stand_current: assert property (p_stand_current) else $error("stand level wrong"); // RULE_11

  property p_resonance;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && !(VELF_IN.midband_en && vel_mag > VELF_IN.midband_vel)) |=> !RESONANCE_COMP_OUT;
  endproperty
  a_resonance: assert property (p_resonance) else $error("compensation out of range"); // RULE_12

  property p_full_step;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && !(VELF_IN.full_en && vel_mag > VELF_IN.full_vel)) |=> !FULL_STEP_OUT;
  endproperty
  a_full_step: assert property (p_full_step) else $error("full step out of range"); // RULE_13

  property p_deadband;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      (CE_IN && an_mag <= VELF_IN.deadband) |=> ANALOG_VEL_OUT == 32'sh0;
  endproperty
  a_deadband: assert property (p_deadband) else $error("motion inside deadband"); // RULE_15

endmodule

// File: bench/host_port_model.sv
/*
  Host side of the drive register port: single word read and write tasks.
  Assumes one clock and requests launched 1 ns after its rising edge.
*/
`timescale 1ns/1ps

module host_port_model (
  // Clock and answer
  input  wire logic        clk_in,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_valid_in,
  // Request
  output logic             rd_en_out,
  output logic             wr_en_out,
  output logic [4:0]       reg_sel_out,
  output logic [31:0]      wr_data_out
);
  // Idle port at time zero
  initial begin
    rd_en_out = 1'b0;
    wr_en_out = 1'b0;
    reg_sel_out = 5'h1f;
    wr_data_out = 32'h0000_0000;
  end

  // Write: one taken edge, then data turns to garbage so stale values never match
  task automatic wr(input logic [4:0] sel, input logic [31:0] data);
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b1;
    reg_sel_out = sel;
    wr_data_out = data;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    wr_data_out = ~data;
  endtask

  // Read: answer waited for under a short bound
  task automatic rd(input logic [4:0] sel, output logic [31:0] data);
    int n;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b1;
    reg_sel_out = sel;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    n = 0;
    while (rd_valid_in !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    // A missing answer hands back unknowns so that the compare fails
    data = (rd_valid_in === 1'b1) ? rd_data_in : 32'hxxxx_xxxx;
  endtask
endmodule

// File: bench/stepper_drive_io_status_logic_tb_top.sv
/*
  Self-checking bench of the drive status and I/O block.
  Assumes the package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`include "stepper_io_params.svh"

module stepper_drive_io_status_logic_tb_top;
  import stepper_io_pkg::*;
  logic              ref_clk, rst_n, ce, pwr_down, fault, power_good, seq_run;
  logic              move_cmd, cont_move, emf, rd_en, wr_en, rd_valid;
  logic              cw_lim, ccw_lim, halt, allow, move_go, res_comp, full_step, an_act;
  logic [6:0]        in_current, prog_sel;
  logic [15:0]       debounce_ms, wind_cur;
  logic [7:0]        analog_code;
  logic [4:0]        reg_sel;
  logic [31:0]       wr_data, rd_data, analog_vel;
  logic [3:0]        out_pins;
  input_masks_t      im;
  output_masks_t     om;
  motion_t           mo;
  power_cfg_t        pw;
  vel_cfg_t          vf;
  int                fails, n_compared;

  // Short millisecond so delays fit the run
  stepper_drive_io_status_logic #(.MS_CYCLES(10)) i_dut (
    .REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .CE_IN(ce), .POWER_DOWN_IN(pwr_down),
    .INPUT_CURRENT_IN(in_current), .DEBOUNCE_MS_IN(debounce_ms), .IN_MASKS_IN(im),
    .OUT_MASKS_IN(om), .FAULT_IN(fault), .POWER_GOOD_IN(power_good), .SEQ_RUN_IN(seq_run),
    .MOVE_CMD_IN(move_cmd), .CONT_MOVE_IN(cont_move), .MOTION_IN(mo), .POWER_IN(pw),
    .VELF_IN(vf), .EMF_RESONANCE_IN(emf), .ANALOG_CODE_IN(analog_code), .RD_EN_IN(rd_en),
    .WR_EN_IN(wr_en), .REG_SEL_IN(reg_sel), .WR_DATA_IN(wr_data), .RD_DATA_OUT(rd_data),
    .RD_VALID_OUT(rd_valid), .CLOCKWISE_TRAVEL_LIMIT_OUT(cw_lim),
    .COUNTERCLOCKWISE_TRAVEL_LIMIT_OUT(ccw_lim), .HALT_OUT(halt), .DRIVE_ALLOW_OUT(allow),
    .PROGRAM_SELECT_OUT(prog_sel), .OUTPUT_PINS_OUT(out_pins), .WINDING_CURRENT_OUT(wind_cur),
    .MOVE_GO_OUT(move_go), .RESONANCE_COMP_OUT(res_comp), .FULL_STEP_OUT(full_step),
    .ANALOG_VEL_OUT(analog_vel), .ANALOG_ACTIVE_OUT(an_act));

  host_port_model i_host (.clk_in(ref_clk), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .rd_en_out(rd_en), .wr_en_out(wr_en), .reg_sel_out(reg_sel), .wr_data_out(wr_data));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [4:0] sel, input logic [31:0] exp);
    logic [31:0] got;
    i_host.rd(sel, got);
    chk(got, exp);
  endtask

  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    {ref_clk, rst_n, ce, pwr_down, fault, power_good, seq_run} = 7'b0010010;
    {move_cmd, cont_move, emf} = 3'b000;
    in_current = 7'h7f;
    debounce_ms = 16'h0002;
    im = {7'h01, 7'h10, 7'h20, 7'h0e, 7'h00, 7'h00};
    om = {4'h1, 4'h2, 4'h4, 4'h8};
    mo = '0;
    pw = {16'h0003, 16'h0002, 8'h32, 8'h14, 16'h03e8};
    vf = {1'b1, 32'd10, 1'b1, 32'd10, 1'b1, 32'd508, 32'd10};
    analog_code = 8'h80;
    tick(4);
    rst_n = 1'b1;
    // Active means no current; input one is bit 0
    in_current = ~7'h4c;
    tick(2);
    rdchk(`IDX_INPUT_WORD, 32'h4c);
    chk(prog_sel, 32'h0c);
    chk({cw_lim, ccw_lim, halt, allow}, 32'h1);
    im.allow = 7'h40;
    im.halt = 7'h10;
    in_current = ~7'h50;
    tick(2);
    chk({cw_lim, ccw_lim, halt, allow}, 32'hb);
    // Clock enable low freezes the filtered state
    ce = 1'b0;
    in_current = ~7'h2e;
    tick(2);
    chk(prog_sel, 32'h0);
    ce = 1'b1;
    tick(2);
    chk(prog_sel, 32'h0e);
    chk({cw_lim, ccw_lim, halt, allow}, 32'h4);
    // Filtered input one must hold 2 ms before it counts
    in_current = ~7'h51;
    tick(3);
    rdchk(`IDX_INPUT_WORD, 32'h50);
    tick(40);
    rdchk(`IDX_INPUT_WORD, 32'h51);
    // Standing 20 %, running 50 % of 1000
    chk(wind_cur, 32'd200);
    rdchk(`IDX_CURRENT, 32'd200);
    move_cmd = 1'b1;
    tick(12);
    chk(wind_cur, 32'd200);
    tick(30);
    chk({move_go, wind_cur}, {15'h0, 1'b1, 16'd500});
    move_cmd = 1'b0;
    tick(5);
    chk(wind_cur, 32'd500);
    tick(30);
    chk(wind_cur, 32'd200);
    // All four output roles at once
    {fault, seq_run} = 2'b11;
    mo = {32'd7, 32'd11, 32'd11, 32'd3};
    tick(2);
    chk(out_pins, 32'hf);
    rdchk(`IDX_OUTPUT_WORD, 32'hf);
    {power_good, seq_run} = 2'b00;
    mo.target_vel = 32'd20;
    tick(2);
    chk({out_pins, full_step, res_comp}, 32'h0a);
    emf = 1'b1;
    tick(2);
    chk(res_comp, 32'h1);
    mo.motor_vel = 32'd10;
    tick(2);
    chk({out_pins, full_step, res_comp}, 32'h08);
    mo.motor_vel = 32'd0;
    tick(2);
    chk(out_pins, 32'h0);
    // Motion snapshot and read-only places
    mo = {-32'sd5, 32'sd3, 32'sd4, 32'sd6};
    tick(1);
    rdchk(`IDX_POSITION, 32'hffff_fffb);
    rdchk(`IDX_MOTOR_VEL, 32'h3);
    rdchk(`IDX_TARGET_VEL, 32'h4);
    rdchk(`IDX_ACCEL, 32'h6);
    i_host.wr(`IDX_OUTPUT_WORD, 32'hffff_ffff);
    i_host.wr(`IDX_FAULT_MASK, 32'h0000_000e);
    mo.motor_vel = 32'd0;
    tick(2);
    rdchk(`IDX_OUTPUT_WORD, 32'h0);
    rdchk(`IDX_FAULT_MASK, 32'h1);
    rdchk(5'h13, 32'h0);
    // Analog velocity: full scale, negative clamp, deadband
    analog_code = 8'hff;
    tick(2);
    chk(analog_vel, 32'h0);
    chk(an_act, 32'h0);
    cont_move = 1'b1;
    tick(2);
    chk(analog_vel, 32'd508);
    chk(an_act, 32'h1);
    analog_code = 8'h00;
    tick(2);
    chk(analog_vel, 32'hffff_fe04);
    analog_code = 8'h81;
    tick(2);
    chk(analog_vel, 32'h0);
    rdchk(`IDX_ANALOG, 32'h81);
    // User variables cleared by power-down and by reset
    i_host.wr(`IDX_USER_BASE, 32'h1234_abcd);
    rdchk(`IDX_USER_BASE, 32'h1234_abcd);
    pwr_down = 1'b1;
    tick(1);
    pwr_down = 1'b0;
    rdchk(`IDX_USER_BASE, 32'h0);
    i_host.wr(`IDX_USER_BASE + 5'h7, 32'h0000_00a5);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rdchk(`IDX_USER_BASE + 5'h7, 32'h0);
    wrap_up();
  end
endmodule
